//--- verilog/hbc_pkg.sv
// package: constants and states for the host bus cycle handshake block
// assumes one 100 MHz local-bus clock shared by all users
package hbc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RDY_TIMER_W = 16;
  localparam logic [15:0] RDY_TIMER_DEFAULT = 16'h0100;
  // ==========================================================
  // cycle states
  typedef enum logic [2:0] {
    HBC_IDLE,
    HBC_TGT_DECODE,
    HBC_TGT_WAIT,
    HBC_MST_FIRST,
    HBC_MST_WAIT
  } hbc_state_type;
endpackage

//--- verilog/hbc_sync.sv
// two-flop synchroniser for pin inputs
// assumes pins are asynchronous to ref_clk_in
`timescale 1ns/1ps
module hbc_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic stage1;
  logic next_stage1;
  logic next_q;
  always_comb begin
    next_stage1 = rst_n_in ? d_in : INIT;
    next_q = rst_n_in ? stage1 : INIT;
  end
  always_ff @(posedge ref_clk_in) begin
    stage1 <= next_stage1;
    q_out <= next_q;
  end
endmodule

//--- verilog/hbc_core.sv
// host bus cycle handshake: burst, ready, time-out, fault forwarding
// assumes internal decode, data path and wait generator on ref_clk_in
//
// Behaviour
// - as owner, burst entered when grant low with target ready low.
// - as owner, grant held low from earlier cycle also enters burst.
// - as target in decoded non-external space with burst request low, drive burst grant low.
// - as target sample inhibit after strobe; low keeps grant high.
// - inhibit ignored while device owns the bus.
// - as owner, ready output driven only on ready timer expiry.
// - host read: ready low once read data valid.
// - host write: ready low once write data captured.
// - external select space: ready from internal wait generator.
// - external select space: ready also on timer expiry.
// - as owner, each transfer ends on target ready input low.
// - external space without other ready uses host wait ack input.
// - on timer expiry assert memory exception with ready.
// - fault enable set and host error low raises interrupt.
// - host error affects nothing but the interrupt.
// - owner burst request low with extended one; extended off at ready.
// - as owner with strobe enabled, strobe low one clock at cycle start.
`timescale 1ns/1ps
module hbc_core
  import hbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic strobe_enable_in,
  input wire logic host_fault_irq_enable_in,
  input wire logic [RDY_TIMER_W-1:0] ready_timer_period_in,
  // bus ownership and internal requests
  input wire logic bus_owner_in,
  input wire logic master_start_in,
  input wire logic master_burst_in,
  input wire logic master_last_in,
  input wire logic target_decoded_in,
  input wire logic target_is_ext_space_in,
  input wire logic target_data_done_in,
  input wire logic waitgen_ready_in,
  input wire logic waitgen_present_in,
  // local bus pins
  input wire logic cycle_strobe_n_in,
  input wire logic burst_request_n_in,
  input wire logic burst_grant_n_in,
  input wire logic burst_inhibit_n_in,
  input wire logic target_ready_input_n_in,
  input wire logic host_waitgen_ack_n_in,
  input wire logic host_error_n_in,
  // pin outputs
  output logic cycle_strobe_n_out,
  output logic cycle_strobe_oe_out,
  output logic burst_request_n_out,
  output logic extended_burst_request_n_out,
  output logic burst_request_oe_out,
  output logic burst_grant_n_out,
  output logic burst_grant_oe_out,
  output logic ready_n_out,
  output logic ready_oe_out,
  output logic memory_exception_n_out,
  output logic memory_exception_oe_out,
  output logic pci_inta_n_out,
  // internal status
  output logic burst_mode_out,
  output logic transfer_done_out,
  output logic timeout_out
);
  // ==========================================================
  // pin synchronisers
  logic s_strobe_n, s_breq_n, s_grant_n, s_inh_n, s_rdyin_n, s_wack_n;
  logic s_err_n;
  hbc_sync u_sy_as (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .d_in(cycle_strobe_n_in), .q_out(s_strobe_n));
  hbc_sync u_sy_br (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .d_in(burst_request_n_in), .q_out(s_breq_n));
  hbc_sync u_sy_bg (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .d_in(burst_grant_n_in), .q_out(s_grant_n));
  hbc_sync u_sy_bi (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .d_in(burst_inhibit_n_in), .q_out(s_inh_n));
  hbc_sync u_sy_ri (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .d_in(target_ready_input_n_in), .q_out(s_rdyin_n));
  hbc_sync u_sy_wa (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .d_in(host_waitgen_ack_n_in), .q_out(s_wack_n));
  hbc_sync u_sy_er (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .d_in(host_error_n_in), .q_out(s_err_n));

  // ==========================================================
  // cycle state
  hbc_state_type state, next_state;
  logic [RDY_TIMER_W-1:0] timer, next_timer;
  logic grant_seen, next_grant_seen;
  logic burst_ok, next_burst_ok;
  logic as_n, next_as_n, as_oe, next_as_oe;
  logic breq_n, next_breq_n, ebreq_n, next_ebreq_n, breq_oe, next_breq_oe;
  logic bg_n, next_bg_n, bg_oe, next_bg_oe;
  logic rdy_n, next_rdy_n, rdy_oe, next_rdy_oe;
  logic memory_exception_n_n, next_memory_exception_n_n, memory_exception_n_oe, next_memory_exception_n_oe;
  logic inta_n, next_inta_n;
  logic bmode, next_bmode, done, next_done, tout, next_tout;
  logic expired;

  assign expired = (timer >= ready_timer_period_in);

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_grant_seen = grant_seen;
    next_burst_ok = burst_ok;
    next_as_n = 1'b1;
    next_as_oe = 1'b0;
    next_breq_n = breq_n;
    next_ebreq_n = ebreq_n;
    next_breq_oe = bus_owner_in;
    next_bg_n = 1'b1;
    next_bg_oe = 1'b0;
    next_rdy_n = 1'b1;
    next_rdy_oe = 1'b0;
    next_memory_exception_n_n = 1'b1;
    next_memory_exception_n_oe = 1'b0;
    next_bmode = bmode;
    next_done = 1'b0;
    next_tout = 1'b0;
    // fault pin only feeds the interrupt
    next_inta_n = ~(host_fault_irq_enable_in & ~s_err_n);
    case (state)
      HBC_IDLE: begin
        next_timer = '0;
        next_grant_seen = 1'b0;
        next_breq_n = 1'b1;
        next_ebreq_n = 1'b1;
        next_bmode = 1'b0;
        if (bus_owner_in && master_start_in) begin
          next_as_n = ~strobe_enable_in;
          next_as_oe = strobe_enable_in;
          next_breq_n = ~master_burst_in;
          next_ebreq_n = ~master_burst_in;
          next_state = HBC_MST_WAIT;
        end else if (!bus_owner_in && !s_strobe_n) begin
          next_state = HBC_TGT_DECODE;
        end
      end
      HBC_TGT_DECODE: begin
        // inhibit and burst request sampled after strobe
        next_burst_ok = target_decoded_in && !target_is_ext_space_in &&
          !s_breq_n && s_inh_n;
        next_timer = timer + 1'b1;
        next_state = HBC_TGT_WAIT;
      end
      HBC_TGT_WAIT: begin
        next_timer = timer + 1'b1;
        next_bg_oe = burst_ok;
        next_bg_n = ~burst_ok;
        next_rdy_oe = 1'b1;
        if (expired) begin
          next_rdy_n = 1'b0;
          next_memory_exception_n_n = 1'b0;
          next_memory_exception_n_oe = 1'b1;
          next_tout = 1'b1;
          next_state = HBC_IDLE;
        end else if (target_is_ext_space_in) begin
          if (waitgen_present_in ? waitgen_ready_in : !s_wack_n) begin
            next_rdy_n = ~waitgen_present_in;
            next_rdy_oe = waitgen_present_in;
            next_done = 1'b1;
            next_state = HBC_IDLE;
          end
        end else if (target_data_done_in) begin
          next_rdy_n = 1'b0;
          next_done = 1'b1;
          next_timer = '0;
          if (!burst_ok || !s_strobe_n) next_state = HBC_IDLE;
        end
        // a burst ends once the space is no longer decoded
        if (bus_owner_in || !target_decoded_in) next_state = HBC_IDLE;
      end
      HBC_MST_WAIT: begin
        next_timer = timer + 1'b1;
        if (!s_grant_n) next_grant_seen = 1'b1;
        if (!s_rdyin_n) begin
          // transfer ends on the slave's ready
          next_done = 1'b1;
          next_timer = '0;
          next_ebreq_n = 1'b1;
          if (!breq_n && (!s_grant_n || grant_seen))
            next_bmode = 1'b1;
          if (master_last_in || !(next_bmode)) begin
            next_state = HBC_IDLE;
          end
        end else if (expired) begin
          next_rdy_oe = 1'b1;
          next_rdy_n = 1'b0;
          next_memory_exception_n_oe = 1'b1;
          next_memory_exception_n_n = 1'b0;
          next_tout = 1'b1;
          next_state = HBC_IDLE;
        end
        if (!bus_owner_in) next_state = HBC_IDLE;
      end
      default: next_state = HBC_IDLE;
    endcase
    // inhibit pin has no say while owning the bus
    if (bus_owner_in) begin
      next_bg_oe = 1'b0;
      next_bg_n = 1'b1;
    end
    if (!rst_n_in) begin
      next_state = HBC_IDLE;
      next_timer = '0;
      next_grant_seen = 1'b0;
      next_burst_ok = 1'b0;
      next_as_n = 1'b1;
      next_as_oe = 1'b0;
      next_breq_n = 1'b1;
      next_ebreq_n = 1'b1;
      next_breq_oe = 1'b0;
      next_bg_n = 1'b1;
      next_bg_oe = 1'b0;
      next_rdy_n = 1'b1;
      next_rdy_oe = 1'b0;
      next_memory_exception_n_n = 1'b1;
      next_memory_exception_n_oe = 1'b0;
      next_inta_n = 1'b1;
      next_bmode = 1'b0;
      next_done = 1'b0;
      next_tout = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    state <= next_state;
    timer <= next_timer;
    grant_seen <= next_grant_seen;
    burst_ok <= next_burst_ok;
    as_n <= next_as_n;
    as_oe <= next_as_oe;
    breq_n <= next_breq_n;
    ebreq_n <= next_ebreq_n;
    breq_oe <= next_breq_oe;
    bg_n <= next_bg_n;
    bg_oe <= next_bg_oe;
    rdy_n <= next_rdy_n;
    rdy_oe <= next_rdy_oe;
    memory_exception_n_n <= next_memory_exception_n_n;
    memory_exception_n_oe <= next_memory_exception_n_oe;
    inta_n <= next_inta_n;
    bmode <= next_bmode;
    done <= next_done;
    tout <= next_tout;
  end

  assign cycle_strobe_n_out = as_n;
  assign cycle_strobe_oe_out = as_oe;
  assign burst_request_n_out = breq_n;
  assign extended_burst_request_n_out = ebreq_n;
  assign burst_request_oe_out = breq_oe;
  assign burst_grant_n_out = bg_n;
  assign burst_grant_oe_out = bg_oe;
  assign ready_n_out = rdy_n;
  assign ready_oe_out = rdy_oe;
  assign memory_exception_n_out = memory_exception_n_n;
  assign memory_exception_oe_out = memory_exception_n_oe;
  assign pci_inta_n_out = inta_n;
  assign burst_mode_out = bmode;
  assign transfer_done_out = done;
  assign timeout_out = tout;

  // ==========================================================
  // assertions
  exc_with_ready_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) !memory_exception_n_n |-> !rdy_n)
    else $error("exception without ready");
  exc_one_clock_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) !memory_exception_n_n |=> memory_exception_n_n && rdy_n)
    else $error("exception held too long");
  strobe_one_clock_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) !as_n |=> as_n)
    else $error("strobe longer than one clock");
  grant_not_owner_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) $past(bus_owner_in) |-> bg_n && !bg_oe)
    else $error("grant driven while owner");
  inhibit_blocks_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    state == HBC_TGT_DECODE && !s_inh_n |=> ##1 bg_n)
    else $error("grant despite inhibit");
  irq_follow_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    host_fault_irq_enable_in && !s_err_n |=> !inta_n)
    else $error("interrupt missing");
  irq_off_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) !host_fault_irq_enable_in |=> inta_n)
    else $error("interrupt while disabled");
  ebreq_first_ready_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    state == HBC_MST_WAIT && !s_rdyin_n |=> ebreq_n)
    else $error("extended request held past ready");
  owner_ready_timeout_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) $past(bus_owner_in) && !rdy_n |-> tout)
    else $error("owner ready without time-out");
  cov_burst: cover property (@(posedge ref_clk_in) $rose(bmode));
  cov_timeout: cover property (@(posedge ref_clk_in) tout);
  cov_tgt_done: cover property (@(posedge ref_clk_in) done && !bg_n);
  cov_irq: cover property (@(posedge ref_clk_in) !inta_n);
endmodule

//--- tb/hbc_slave.sv
// far-side slave model: answers cycles that the device masters
// assumes strobe and burst request wires resolved by the bench
`timescale 1ns/1ps
module hbc_slave (
  // clock and cycle pins
  input wire logic ref_clk_in,
  input wire logic strobe_n_in,
  input wire logic breq_n_in,
  // behaviour: grant 0 none, 1 with ready, 2 from strobe on
  input wire logic mute_in,
  input wire logic [1:0] grant_in,
  input wire logic [3:0] delay_in,
  input wire logic [1:0] beats_in,
  // answers, pulled up when idle
  output logic ready_n_out,
  output logic grant_n_out
);
  int cnt = 0;
  int left = 0;
  logic brst = 1'b0;
  initial ready_n_out = 1'b1;
  initial grant_n_out = 1'b1;
  always @(posedge ref_clk_in) begin
    #1;
    ready_n_out = 1'b1;
    if (strobe_n_in === 1'b0 && !mute_in) begin
      left = beats_in;
      cnt = delay_in;
      brst = !breq_n_in;
    end else if (left > 0) begin
      if (cnt == 0) begin
        ready_n_out = 1'b0;
        left--;
        cnt = delay_in;
      end else
        cnt--;
    end
    grant_n_out = !(brst && grant_in != 0 &&
      (!ready_n_out || (grant_in == 2 && left > 0)));
  end
endmodule

//--- tb/hbc_core_test.sv
// self-checking bench for the host bus cycle handshake core
// assumes hbc_slave on the far side; host pins driven by the bench
`timescale 1ns/1ps
module hbc_core_test;
  import hbc_pkg::*;
  logic clk = 0, rst_n = 0, en_irq = 0, owner = 0, start = 0, burst = 0;
  logic last = 0, dec = 0, ext = 0, done_p = 0, wg_rdy = 0, wg_pres = 0;
  logic h_stb_n = 1, h_breq_n = 1, inh_n = 1, ack_n = 1, err_n = 1;
  logic so_n, so_oe, br_n, ebr_n, br_oe, bg_n, bg_oe, rdy_n, rdy_oe;
  logic exc_n, exc_oe, inta_n, bmode, tdone, tout, s_rdy_n, s_gnt_n;
  logic s_mute = 0;
  logic [1:0] s_gnt = 0, s_beats = 1;
  logic [3:0] s_dly = 0;
  wire logic stb_w = so_oe ? so_n : h_stb_n;
  wire logic breq_w = br_oe ? br_n : h_breq_n;
  wire logic gnt_w = bg_oe ? bg_n : s_gnt_n;
  int n_fail = 0, checks_done = 0, cyc = 0;
  int rdy_lo = 0, exc_lo = 0, both_lo = 0;
  // ==========================================================
  // design and far side
  hbc_core i_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .strobe_enable_in(1'b1), .host_fault_irq_enable_in(en_irq),
    .ready_timer_period_in(16'h0018), .bus_owner_in(owner),
    .master_start_in(start), .master_burst_in(burst),
    .master_last_in(last), .target_decoded_in(dec),
    .target_is_ext_space_in(ext), .target_data_done_in(done_p),
    .waitgen_ready_in(wg_rdy), .waitgen_present_in(wg_pres),
    .cycle_strobe_n_in(stb_w), .burst_request_n_in(breq_w),
    .burst_grant_n_in(gnt_w), .burst_inhibit_n_in(inh_n),
    .target_ready_input_n_in(s_rdy_n), .host_waitgen_ack_n_in(ack_n),
    .host_error_n_in(err_n), .cycle_strobe_n_out(so_n),
    .cycle_strobe_oe_out(so_oe), .burst_request_n_out(br_n),
    .extended_burst_request_n_out(ebr_n), .burst_request_oe_out(br_oe),
    .burst_grant_n_out(bg_n), .burst_grant_oe_out(bg_oe),
    .ready_n_out(rdy_n), .ready_oe_out(rdy_oe),
    .memory_exception_n_out(exc_n), .memory_exception_oe_out(exc_oe),
    .pci_inta_n_out(inta_n), .burst_mode_out(bmode),
    .transfer_done_out(tdone), .timeout_out(tout));
  hbc_slave i_slave (.ref_clk_in(clk), .strobe_n_in(stb_w),
    .breq_n_in(breq_w), .mute_in(s_mute || !owner), .grant_in(s_gnt),
    .delay_in(s_dly), .beats_in(s_beats), .ready_n_out(s_rdy_n),
    .grant_n_out(s_gnt_n));
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    rdy_lo += int'(rdy_n === 1'b0);
    exc_lo += int'(exc_n === 1'b0);
    both_lo += int'(rdy_n === 1'b0 && exc_n === 1'b0);
    if (cyc == 6000) begin
      n_fail++;
      results;
    end
  end
  // ==========================================================
  // helpers
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task results;
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic irq();
    int r0;
    r0 = rdy_lo;
    en_irq = 1'($urandom);
    err_n = 1'($urandom);
    repeat (4) tick;
    chk(inta_n === !(en_irq && !err_n), "interrupt");
    chk(rdy_lo == r0 && exc_n === 1'b1, "error side effect");
  endtask
  task automatic master(logic b, int g, logic m);
    int n, r0, e0, b0;
    r0 = rdy_lo;
    e0 = exc_lo;
    b0 = both_lo;
    owner = 1;
    burst = b;
    last = !b;
    inh_n = 1'($urandom);
    s_gnt = 2'(g);
    s_mute = m;
    s_dly = 4'($urandom % 3);
    s_beats = b ? 2'h2 : 2'h1;
    start = 1;
    tick;
    start = 0;
    for (n = 0; n < 4 && so_n !== 1'b0; n++) tick;
    chk(so_n === 1'b0, "no strobe");
    chk(br_n === !b && ebr_n === !b, "burst request");
    tick;
    chk(so_n === 1'b1, "strobe length");
    if (m) begin
      for (n = 0; n < 40 && tout !== 1'b1; n++) tick;
      repeat (3) tick;
      chk(n < 40 && rdy_lo - r0 == 1 && exc_lo - e0 == 1
        && both_lo - b0 == 1, "time-out pulse");
    end else begin
      for (n = 0; n < 20 && tdone !== 1'b1; n++) tick;
      chk(n < 20 && ebr_n === 1'b1, "first ready");
      chk(bmode === (b && g != 0), "burst mode");
      last = 1;
      if (b && g != 0) begin
        tick;
        for (n = 0; n < 20 && tdone !== 1'b1; n++) tick;
        chk(n < 20, "second ready");
      end
      chk(rdy_lo == r0, "owner ready");
    end
    owner = 0;
    burst = 0;
    last = 0;
    repeat (4) tick;
  endtask
  task automatic target(int p, logic rq);
    int n, r0, e0;
    r0 = rdy_lo;
    e0 = exc_lo;
    inh_n = 1'($urandom);
    dec = 1;
    ext = p != 0;
    wg_pres = p == 1;
    h_breq_n = !rq;
    h_stb_n = 0;
    tick;
    h_stb_n = 1;
    repeat (5) tick;
    chk(bg_n === !(rq && inh_n && !ext), "burst grant");
    done_p = p == 0;
    wg_rdy = p == 1;
    ack_n = p != 2;
    tick;
    done_p = 0;
    wg_rdy = 0;
    ack_n = 1;
    for (n = 0; n < 40 && rdy_lo == r0 && tdone !== 1'b1; n++) tick;
    repeat (2) tick;
    chk(n < 40 && rdy_lo - r0 == int'(p != 2),
      "target ready");
    chk(exc_lo - e0 == int'(p == 3), "exception");
    dec = 0;
    ext = 0;
    h_breq_n = 1;
    repeat (4) tick;
  endtask
  initial begin
    void'($urandom(64012));
    repeat (2) tick;
    rst_n = 1;
    tick;
    for (int g = 0; g < 3; g++) master(1, g, 0);
    master(0, 0, 1);
    for (int p = 0; p < 4; p++) target(p, 1);
    for (int i = 0; i < 30; i++) begin
      case ($urandom % 3)
        0: irq();
        1: master(1'($urandom), $urandom % 3, ($urandom % 4) == 0);
        default: target($urandom % 4, 1'($urandom));
      endcase
    end
    results;
  end
endmodule
